/* File: hth_chan.sv */
`timescale 1ns/1ps
`include "hth_defs.svh"
module hth_chan
  import hth_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire hth_temp_t temp_i,
  input wire hth_temp_t setpt_i,
  input wire logic [9:0] cur_i,
  input wire logic [9:0] gf_i,
  input wire logic [9:0] gf_alarm_lvl_i,
  input wire logic [9:0] gf_trip_lvl_i,
  output logic demand_o,
  output logic open_o,
  output logic short_o,
  output logic [9:0] cur_o,
  output logic ovl_o,
  output logic gf_alarm_o,
  output logic gf_trip_o
);
  logic bad;

  // A sensor out of range cannot be trusted, so it never calls for heat.
  assign bad = (temp_i < `HTH_TEMP_MIN) || (temp_i > `HTH_TEMP_MAX);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      open_o <= 1'b0;
      short_o <= 1'b0;
    end
    else
    begin
      short_o <= temp_i < `HTH_TEMP_MIN; // [R13]
      open_o <= temp_i > `HTH_TEMP_MAX; // [R13]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      demand_o <= 1'b0;
    else if (bad)
      demand_o <= 1'b0;
    else if (temp_i < setpt_i)
      demand_o <= 1'b1; // [R11]
    else if (temp_i > setpt_i)
      demand_o <= 1'b0; // [R11]
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cur_o <= '0;
      ovl_o <= 1'b0;
      gf_alarm_o <= 1'b0;
      gf_trip_o <= 1'b0;
    end
    else
    begin
      ovl_o <= cur_i > `HTH_CUR_MAX; // [R15]
      cur_o <= (cur_i > `HTH_CUR_MAX) ? 10'h0 : cur_i; // [R15]
      gf_alarm_o <= (gf_alarm_lvl_i != `HTH_GF_OFF) && (gf_i > gf_alarm_lvl_i); // [R16]
      gf_trip_o <= (gf_trip_lvl_i != `HTH_GF_OFF) && (gf_i > gf_trip_lvl_i); // [R16]
    end
  end

  AST_CH_OPEN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R13]
    temp_i > `HTH_TEMP_MAX |=> open_o && !short_o && !demand_o) else $error("open sensor not reported");
  AST_CH_DEMAND: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R11]
    !bad && temp_i < setpt_i |=> demand_o) else $error("no heat below setpoint");
endmodule

/* File: hth_defs.svh */
`ifndef HTH_DEFS_SVH
`define HTH_DEFS_SVH
`define HTH_CLK_PERIOD_NS 4
`define HTH_NS_PER_SEC 1000000000
`define HTH_SEC_PER_HOUR 3600
`define HTH_TEST_OFF 5'h00
`define HTH_TEST_MAX_H 5'h18
`define HTH_TEST_CONT 5'h19
`define HTH_TEMP_MIN 12'shfce
`define HTH_TEMP_MAX 12'sh1f4
`define HTH_CUR_MAX 10'h12c
`define HTH_GF_OFF 10'h000
`define HTH_FLASH_SEC_DEF 8'h03
`define HTH_DEF_MSG_LAST 2'h2
`define HTH_DISP_CELL_LAST 5'h1f
`define HTH_DISP_COL_MSB 3
`define HTH_ALM_OPEN 0
`define HTH_ALM_GFAL 1
`define HTH_ALM_TRIP 2
`define HTH_ALM_BITS 3
`endif

/* File: hth_pkg.sv */
package hth_pkg;
  typedef enum logic [1:0] {HTH_VIEW_DEFAULT, HTH_VIEW_SETPT, HTH_VIEW_MEAS, HTH_VIEW_STATUS} hth_view_t;
  typedef enum logic [1:0] {HTH_FL_NONE, HTH_FL_STORED, HTH_FL_NOT_STORED, HTH_FL_RESET_DENIED} hth_flash_t;
  typedef logic [4:0] hth_tcode_t;
  typedef logic signed [11:0] hth_temp_t;
endpackage

/* File: hth_plant_model.sv */
`timescale 1ns/1ps
module hth_plant_model(
  input wire logic core_clk_i,
  input wire logic [1:0] heater_i,
  input wire logic [9:0] load_i,
  output logic [1:0][9:0] cur_o
);
  // A switched-off heater draws nothing, so the bench can tell forcing from load.
  always_ff @(posedge core_clk_i)
  begin
    cur_o[0] <= heater_i[0] ? load_i : 10'h000;
    cur_o[1] <= heater_i[1] ? load_i : 10'h000;
  end
endmodule

/* File: hth_test_timer.sv */
`timescale 1ns/1ps
`include "hth_defs.svh"
module hth_test_timer
  import hth_pkg::*;
#(
  parameter int SEC_PER_HOUR = `HTH_SEC_PER_HOUR
)
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sec_tick_i,
  hth_tmr_if.tmr tif
);
  logic [11:0] sec_q;
  logic [4:0] hours_q;
  logic cont_q;
  logic hour_tick;

  assign hour_tick = sec_tick_i && (sec_q == 12'(SEC_PER_HOUR - 1));
  assign tif.force_on = cont_q || (hours_q != 5'h0);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sec_q <= '0;
    else if (tif.commit || hour_tick)
      sec_q <= '0; // [R25]
    else if (sec_tick_i)
      sec_q <= sec_q + 12'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hours_q <= '0;
      cont_q <= 1'b0;
    end
    else if (tif.commit)
    begin
      hours_q <= (tif.code <= `HTH_TEST_MAX_H) ? tif.code : 5'h0; // [R2]
      cont_q <= (tif.code == `HTH_TEST_CONT); // [R6]
    end
    else if (hour_tick && hours_q != 5'h0)
      hours_q <= hours_q - 5'h1; // [R4]
  end

  AST_TMR_CANCEL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R6]
    tif.commit && tif.code == `HTH_TEST_OFF |=> !tif.force_on) else $error("disable did not cancel test");
  AST_TMR_END: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R4]
    hour_tick && !tif.commit && !cont_q && hours_q == 5'h1 |=> !tif.force_on) else $error("test outlived its hours");
endmodule

/* File: hth_tmr_if.sv */
`timescale 1ns/1ps
interface hth_tmr_if;
  import hth_pkg::*;
  logic commit;
  hth_tcode_t code;
  logic force_on;
  modport ctl (output commit, output code, input force_on);
  modport tmr (input commit, input code, output force_on);
endinterface

/* File: hth_top.sv */
`timescale 1ns/1ps
`include "hth_defs.svh"
// How it works
// [R1] Storing a test value with the permit switch off is refused and flashes not-stored.
// [R2] Test duration is disabled, one to twenty-four hours, or continuous.
// [R3] An active heater test energizes the heater; a ground fault trip still removes it.
// [R4] A timed test ends by itself once its hours have elapsed.
// [R5] The heater lamp is lit whenever any heater output is on.
// [R6] Continuous test runs until power loss or disabled is stored; disabled cancels at once.
// [R7] A status warning stands while any heater or the alarm is forced by a test.
// [R8] A separate alarm test, same durations, forces alarm output and alarm lamp on.
// [R9] With no key for the idle period the view returns to default messages.
// [R10] Up, down and store do nothing outside the settings view.
// [R11] Heat turns on below setpoint and stays on until above setpoint.
// [R12] Channel one is controlled by sensor one, channel two by sensor two.
// [R13] Readings below minus fifty report short; above five hundred report open.
// [R14] An open sensor raises an alarm for its channel.
// [R15] Current is reported in tenths of an ampere; above thirty amperes reports overload.
// [R16] Ground fault above alarm level alarms; above trip level removes heater power.
// [R17] Statistics run continuously until cleared; the start of each interval is recorded.
// [R18] The default view cycles three messages; settings, readings or status keys override it.
// [R19] Reset clears only alarms whose cause is gone; active ones stay latched.
// [R20] The alarm lamp is dark without alarms and flashes when any alarm exists.
// [R21] The communication lamp toggles with serial traffic.
// [R22] The display is two lines of sixteen characters.
// [R23] Key notices flash for a configurable time, three seconds by default.
// [R24] Heater drive is demand or test forcing, gated off by a latched trip.
// [R25] Test hours come from an exact hour prescaler restarted on each commit.
module hth_top
  import hth_pkg::*;
#(
  parameter int NCH = 2,
  parameter int CYC_PER_SEC = `HTH_NS_PER_SEC / `HTH_CLK_PERIOD_NS,
  parameter int SEC_PER_HOUR = `HTH_SEC_PER_HOUR
)
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic prog_en_i,
  input wire logic key_setpt_i,
  input wire logic key_meas_i,
  input wire logic key_status_i,
  input wire logic key_msg_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_store_i,
  input wire logic key_reset_i,
  input wire logic [1:0] test_item_i,
  input wire logic flash_time_we_i,
  input wire logic [7:0] flash_time_s_i,
  input wire logic [7:0] idle_time_s_i,
  input wire logic [NCH-1:0][11:0] temp_i,
  input wire logic [NCH-1:0][11:0] setpt_i,
  input wire logic [NCH-1:0][9:0] cur_i,
  input wire logic [NCH-1:0][9:0] gf_i,
  input wire logic [9:0] gf_alarm_lvl_i,
  input wire logic [9:0] gf_trip_lvl_i,
  input wire logic comm_evt_i,
  input wire logic self_fail_i,
  input wire logic stats_clear_i,
  output logic [NCH-1:0] heater_o,
  output logic alarm_o,
  output logic power_lamp_o,
  output logic heater_lamp_o,
  output logic comm_lamp_o,
  output logic fail_lamp_o,
  output logic alarm_lamp_o,
  output logic test_warn_o,
  output hth_view_t view_o,
  output logic [1:0] default_msg_o,
  output hth_flash_t flash_o,
  output logic [4:0] edit_val_o,
  output logic [NCH-1:0] sensor_open_flag_o,
  output logic [NCH-1:0] sensor_short_flag_o,
  output logic [NCH-1:0][9:0] cur_tenths_o,
  output logic [NCH-1:0] cur_ovl_o,
  output logic [`HTH_ALM_BITS*NCH-1:0] alarm_latch_o,
  output logic [NCH-1:0][31:0] on_sec_o,
  output logic [31:0] uptime_s_o,
  output logic [31:0] interval_start_o,
  output logic disp_row_o,
  output logic [`HTH_DISP_COL_MSB:0] disp_col_o
);
  logic [31:0] cyc_q;
  logic blink_q;
  logic sec_tick;
  hth_view_t view_q;
  logic [7:0] idle_q;
  logic idle_to;
  logic [7:0] dm_sec_q;
  logic [1:0] dm_q;
  hth_tcode_t edit_q;
  logic store_try;
  logic commit_w;
  hth_flash_t flash_q;
  logic [7:0] flash_left_q;
  logic [7:0] flash_sec_q;
  logic [`HTH_ALM_BITS*NCH-1:0] cond_w;
  logic [`HTH_ALM_BITS*NCH-1:0] lat_q;
  logic deny_w;
  logic [NCH:0] force_w;
  logic [NCH-1:0] demand_w;
  logic [NCH-1:0] heater_d;
  logic [NCH-1:0] heater_q;
  logic heater_lamp_q;
  logic alarm_q;
  logic alarm_lamp_q;
  logic warn_q;
  logic comm_q;
  logic power_q;
  logic fail_q;
  logic [NCH-1:0][31:0] on_sec_q;
  logic [31:0] uptime_q;
  logic [31:0] istart_q;
  logic [4:0] disp_q;

  assign sec_tick = (cyc_q == 32'(CYC_PER_SEC - 1));

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cyc_q <= '0;
    else if (sec_tick)
      cyc_q <= '0;
    else
      cyc_q <= cyc_q + 32'h1;
  end

  // The lamp blink runs at one hertz so a flashing alarm is distinct from a steady forced one.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      blink_q <= 1'b0;
    else if (sec_tick || cyc_q == 32'(CYC_PER_SEC / 2 - 1))
      blink_q <= !blink_q;
  end

  assign idle_to = (view_q != HTH_VIEW_DEFAULT) && (idle_time_s_i != 8'h0) && (idle_q >= idle_time_s_i);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      view_q <= HTH_VIEW_DEFAULT;
    else if (key_setpt_i)
      view_q <= HTH_VIEW_SETPT; // [R18]
    else if (key_meas_i)
      view_q <= HTH_VIEW_MEAS; // [R18]
    else if (key_status_i)
      view_q <= HTH_VIEW_STATUS; // [R18]
    else if (idle_to)
      view_q <= HTH_VIEW_DEFAULT; // [R9]
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      idle_q <= '0;
    else if (view_q == HTH_VIEW_DEFAULT || key_setpt_i || key_meas_i || key_status_i || key_msg_i ||
             key_up_i || key_down_i || key_store_i || key_reset_i)
      idle_q <= '0; // [R9]
    else if (sec_tick && !idle_to)
      idle_q <= idle_q + 8'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dm_q <= '0;
      dm_sec_q <= '0;
    end
    else if (view_q != HTH_VIEW_DEFAULT)
      dm_sec_q <= '0;
    else if (sec_tick && dm_sec_q + 8'h1 >= flash_sec_q)
    begin
      dm_sec_q <= '0;
      dm_q <= (dm_q == `HTH_DEF_MSG_LAST) ? 2'h0 : dm_q + 2'h1; // [R18]
    end
    else if (sec_tick)
      dm_sec_q <= dm_sec_q + 8'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      edit_q <= `HTH_TEST_OFF;
    else
      unique case (view_q)
        HTH_VIEW_SETPT:
          if (key_up_i && edit_q != `HTH_TEST_CONT)
            edit_q <= edit_q + 5'h1; // [R2]
          else if (key_down_i && edit_q != `HTH_TEST_OFF)
            edit_q <= edit_q - 5'h1; // [R2]
        HTH_VIEW_DEFAULT, HTH_VIEW_MEAS, HTH_VIEW_STATUS:
          edit_q <= edit_q; // [R10]
      endcase
  end

  assign store_try = key_store_i && (view_q == HTH_VIEW_SETPT); // [R10]
  assign commit_w = store_try && prog_en_i; // [R1]
  assign deny_w = key_reset_i && |(lat_q & cond_w);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flash_sec_q <= `HTH_FLASH_SEC_DEF; // [R23]
    else if (flash_time_we_i)
      flash_sec_q <= flash_time_s_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flash_q <= HTH_FL_NONE;
    else if (store_try)
      flash_q <= prog_en_i ? HTH_FL_STORED : HTH_FL_NOT_STORED; // [R1]
    else if (deny_w)
      flash_q <= HTH_FL_RESET_DENIED;
    else if (sec_tick && flash_left_q <= 8'h1)
      flash_q <= HTH_FL_NONE; // [R23]
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flash_left_q <= '0;
    else if (store_try || deny_w)
      flash_left_q <= flash_sec_q; // [R23]
    else if (sec_tick && flash_left_q != 8'h0)
      flash_left_q <= flash_left_q - 8'h1;
  end

  genvar c;
  generate
    for (c = 0; c <= NCH; c++)
    begin : g_tmr
      hth_tmr_if tif();
      assign tif.commit = commit_w && (test_item_i == 2'(c));
      assign tif.code = edit_q;
      assign force_w[c] = tif.force_on;
      hth_test_timer #(.SEC_PER_HOUR(SEC_PER_HOUR)) u_tmr (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .sec_tick_i(sec_tick),
        .tif(tif.tmr)
      );
    end
    for (c = 0; c < NCH; c++)
    begin : g_ch
      hth_chan u_ch (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .temp_i(temp_i[c]), // [R12]
        .setpt_i(setpt_i[c]),
        .cur_i(cur_i[c]),
        .gf_i(gf_i[c]),
        .gf_alarm_lvl_i(gf_alarm_lvl_i),
        .gf_trip_lvl_i(gf_trip_lvl_i),
        .demand_o(demand_w[c]),
        .open_o(cond_w[`HTH_ALM_BITS*c+`HTH_ALM_OPEN]),
        .short_o(sensor_short_flag_o[c]),
        .cur_o(cur_tenths_o[c]),
        .ovl_o(cur_ovl_o[c]),
        .gf_alarm_o(cond_w[`HTH_ALM_BITS*c+`HTH_ALM_GFAL]),
        .gf_trip_o(cond_w[`HTH_ALM_BITS*c+`HTH_ALM_TRIP])
      );
      assign sensor_open_flag_o[c] = cond_w[`HTH_ALM_BITS*c+`HTH_ALM_OPEN];
      // [R3] [R24]
      assign heater_d[c] = (demand_w[c] || force_w[c]) && !lat_q[`HTH_ALM_BITS*c+`HTH_ALM_TRIP];
    end
  endgenerate

  // A new cause sets its bit in the same cycle that reset tries to clear it.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lat_q <= '0;
    else
      lat_q <= cond_w | (lat_q & ~({`HTH_ALM_BITS*NCH{key_reset_i}} & ~cond_w)); // [R14] [R16] [R19]
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      heater_q <= '0;
      heater_lamp_q <= 1'b0;
    end
    else
    begin
      heater_q <= heater_d;
      heater_lamp_q <= |heater_d; // [R5]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      alarm_q <= 1'b0;
      alarm_lamp_q <= 1'b0;
      warn_q <= 1'b0;
    end
    else
    begin
      alarm_q <= (|lat_q) || force_w[NCH]; // [R8]
      alarm_lamp_q <= force_w[NCH] || ((|lat_q) && blink_q); // [R8] [R20]
      warn_q <= |force_w; // [R7]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      comm_q <= 1'b0;
      power_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      comm_q <= comm_q ^ comm_evt_i; // [R21]
      power_q <= 1'b1;
      fail_q <= self_fail_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      uptime_q <= '0;
      istart_q <= '0;
      on_sec_q <= '0;
    end
    else
    begin
      if (sec_tick)
        uptime_q <= uptime_q + 32'h1;
      if (stats_clear_i)
        istart_q <= uptime_q; // [R17]
      for (int i = 0; i < NCH; i++)
        if (stats_clear_i)
          on_sec_q[i] <= '0; // [R17]
        else if (sec_tick && heater_q[i])
          on_sec_q[i] <= on_sec_q[i] + 32'h1; // [R17]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      disp_q <= '0;
    else if (disp_q == `HTH_DISP_CELL_LAST)
      disp_q <= '0; // [R22]
    else
      disp_q <= disp_q + 5'h1;
  end

  assign heater_o = heater_q;
  assign heater_lamp_o = heater_lamp_q;
  assign alarm_o = alarm_q;
  assign alarm_lamp_o = alarm_lamp_q;
  assign test_warn_o = warn_q;
  assign comm_lamp_o = comm_q;
  assign power_lamp_o = power_q;
  assign fail_lamp_o = fail_q;
  assign view_o = view_q;
  assign default_msg_o = dm_q;
  assign flash_o = flash_q;
  assign edit_val_o = edit_q;
  assign alarm_latch_o = lat_q;
  assign on_sec_o = on_sec_q;
  assign uptime_s_o = uptime_q;
  assign interval_start_o = istart_q;
  assign disp_row_o = disp_q[4];
  assign disp_col_o = disp_q[`HTH_DISP_COL_MSB:0];

  AST_PROG_LOCK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R1]
    store_try && !prog_en_i |=> flash_q == HTH_FL_NOT_STORED) else $error("locked store not refused");
  AST_TEST_FORCE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R3]
    force_w[0] && !lat_q[`HTH_ALM_TRIP] |=> heater_o[0]) else $error("test did not energize heater");
  AST_TRIP_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R24]
    lat_q[`HTH_ALM_TRIP] |=> !heater_o[0]) else $error("heater on during trip");
  AST_LAMP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R5]
    heater_lamp_o == (|heater_o)) else $error("heater lamp mismatch");
  AST_WARN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R7]
    (|force_w) |=> test_warn_o) else $error("no warning while forced");
  AST_ALARM_FORCE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R8]
    force_w[NCH] |=> alarm_o && alarm_lamp_o) else $error("alarm test not forcing");
  AST_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R9]
    idle_to && !key_setpt_i && !key_meas_i && !key_status_i |=> view_q == HTH_VIEW_DEFAULT)
    else $error("idle return missed");
  AST_MEAS_RO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R10]
    view_q == HTH_VIEW_MEAS |=> $stable(edit_q)) else $error("value changed in readings view");
  AST_RESET_KEEP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R19]
    key_reset_i && lat_q[0] && cond_w[0] |=> lat_q[0]) else $error("active alarm cleared");
  AST_RESET_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R19]
    key_reset_i && lat_q[0] && !cond_w[0] |=> !lat_q[0]) else $error("stale alarm kept");
  AST_DARK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R20]
    !(|lat_q) && !force_w[NCH] |=> !alarm_lamp_o) else $error("alarm lamp lit without alarm");
  AST_COMM: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [R21]
    comm_evt_i |=> comm_lamp_o != $past(comm_lamp_o)) else $error("comm lamp did not toggle");

  COV_CONT: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) commit_w && edit_q == `HTH_TEST_CONT);
  COV_DENY: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) deny_w);
  COV_IDLE: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) idle_to ##1 view_q == HTH_VIEW_DEFAULT);
endmodule

/* File: tb_heater_thermostat_test_panel.sv */
`timescale 1ns/1ps
module tb_heater_thermostat_test_panel;
  import hth_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic prog_en = 1'b1;
  logic comm_evt = 1'b0;
  logic stats_clr = 1'b0;
  logic self_fail = 1'b0;
  logic flash_we = 1'b0;
  logic [7:0] flash_s = 8'h03;
  logic [7:0] keys = 8'h00;
  logic [7:0] idle_s = 8'h00;
  logic [1:0] item = 2'h0;
  logic [1:0][11:0] temp = '0;
  logic [1:0][11:0] setpt = '0;
  logic [1:0][9:0] cur, gf = '0, tenths;
  logic [9:0] load = 10'h000;
  logic [1:0] heater, sopen, sshort, ovl, dmsg;
  logic alarm, pwr, hlamp, clamp, flamp, alamp, warn, row;
  hth_view_t view;
  hth_flash_t flash;
  logic [4:0] edit;
  logic [5:0] latch;
  logic [1:0][31:0] on_s;
  logic [31:0] up_s, int_s;
  logic [3:0] col;
  integer fails = 0, n_checks = 0, seed = 32'h70201f77, i, n, c, t;
  integer exp_h[2];
  initial forever #2 clk = ~clk;
  hth_plant_model plant_u (.core_clk_i(clk), .heater_i(heater), .load_i(load), .cur_o(cur));
  hth_top #(.NCH(2), .CYC_PER_SEC(20), .SEC_PER_HOUR(3)) dut_u (
    .core_clk_i(clk), .rst_b_i(rst_b), .prog_en_i(prog_en), .key_setpt_i(keys[0]),
    .key_meas_i(keys[1]), .key_status_i(keys[2]), .key_msg_i(keys[3]), .key_up_i(keys[4]),
    .key_down_i(keys[5]), .key_store_i(keys[6]), .key_reset_i(keys[7]), .test_item_i(item),
    .flash_time_we_i(flash_we), .flash_time_s_i(flash_s), .idle_time_s_i(idle_s), .temp_i(temp),
    .setpt_i(setpt), .cur_i(cur), .gf_i(gf), .gf_alarm_lvl_i(10'h014), .gf_trip_lvl_i(10'h01e),
    .comm_evt_i(comm_evt), .self_fail_i(self_fail), .stats_clear_i(stats_clr), .heater_o(heater),
    .alarm_o(alarm), .power_lamp_o(pwr), .heater_lamp_o(hlamp), .comm_lamp_o(clamp),
    .fail_lamp_o(flamp), .alarm_lamp_o(alamp), .test_warn_o(warn), .view_o(view),
    .default_msg_o(dmsg), .flash_o(flash), .edit_val_o(edit), .sensor_open_flag_o(sopen),
    .sensor_short_flag_o(sshort), .cur_tenths_o(tenths), .cur_ovl_o(ovl), .alarm_latch_o(latch),
    .on_sec_o(on_s), .uptime_s_o(up_s), .interval_start_o(int_s), .disp_row_o(row), .disp_col_o(col));
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic key(input int k);
    keys = 8'h01 << k;
    cyc(1);
    keys = 8'h00;
    cyc(1);
  endtask
  task automatic wflash;
    n = 0;
    while (flash !== HTH_FL_NONE && n < 200)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
  initial
  begin
    exp_h[0] = 0;
    exp_h[1] = 0;
    cyc(3);
    rst_b = 1'b1;
    cyc(2);
    chk_bit("power_lamp", 1'b1, pwr);
    // Random temperatures around the setpoint; the bench keeps its own hysteresis state.
    for (i = 0; i < 12; i++)
    begin
      for (c = 0; c < 2; c++)
      begin
        t = $random(seed) % 4;
        temp[c] = 12'(t);
        if (t < 0) exp_h[c] = 1;
        else if (t > 0) exp_h[c] = 0;
      end
      cyc(5);
      chk_bit("heater0", exp_h[0][0], heater[0]);
      chk_bit("heater1", exp_h[1][0], heater[1]);
      chk_bit("heater_lamp", exp_h[0][0] | exp_h[1][0], hlamp);
    end
    setpt = {12'd50, 12'd50};
    temp = {12'hfcd, 12'd501};
    cyc(5);
    chk_val("open_flags", 2'b01, sopen);
    chk_val("short_flags", 2'b10, sshort);
    chk_bit("open_latch", 1'b1, latch[0]);
    chk_bit("heater_open", 1'b0, heater[0]);
    temp = {12'd100, 12'd0};
    load = 10'h12c;
    cyc(6);
    chk_val("tenths", 10'h12c, tenths[0]);
    chk_bit("ovl", 1'b0, ovl[0]);
    load = 10'h12d;
    cyc(4);
    chk_val("tenths_ovl", 10'h000, tenths[0]);
    chk_bit("ovl_hi", 1'b1, ovl[0]);
    gf[0] = 10'd25;
    cyc(4);
    chk_val("gf_alarm", 6'b000011, latch);
    chk_bit("alarm_out", 1'b1, alarm);
    gf[0] = 10'd35;
    cyc(4);
    chk_bit("trip_heater", 1'b0, heater[0]);
    n = 0;
    while (alamp !== 1'b1 && n < 25)
    begin
      cyc(1);
      n++;
    end
    chk_bit("alarm_lamp_on", 1'b1, alamp);
    n = 0;
    while (alamp === 1'b1 && n < 25)
    begin
      cyc(1);
      n++;
    end
    chk_bit("alarm_lamp_flash", 1'b0, alamp);
    key(7);
    chk_val("reset_denied", HTH_FL_RESET_DENIED, flash);
    chk_val("latch_kept", 6'b000110, latch);
    gf[0] = 10'd0;
    cyc(2);
    key(7);
    cyc(2);
    chk_val("latch_clear", 6'b000000, latch);
    cyc(3);
    chk_bit("heater_back", 1'b1, heater[0]);
    chk_bit("alarm_lamp_dark", 1'b0, alamp);
    wflash();
    key(1);
    chk_val("view_meas", HTH_VIEW_MEAS, view);
    key(4);
    key(6);
    chk_val("meas_edit", 5'h00, edit);
    chk_val("meas_flash", HTH_FL_NONE, flash);
    key(0);
    key(4);
    chk_val("edit_one", 5'h01, edit);
    prog_en = 1'b0;
    item = 2'h1;
    key(6);
    chk_val("not_stored", HTH_FL_NOT_STORED, flash);
    cyc(2);
    chk_bit("no_force", 1'b0, heater[1]);
    wflash();
    prog_en = 1'b1;
    key(6);
    chk_val("stored", HTH_FL_STORED, flash);
    cyc(1);
    chk_bit("forced1", 1'b1, heater[1]);
    chk_bit("warn", 1'b1, warn);
    n = 0;
    while (heater[1] === 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk_bit("hour_end", 1'b1, n >= 38 && n <= 62);
    cyc(2);
    chk_bit("warn_off", 1'b0, warn);
    for (i = 0; i < 24; i++) key(4);
    chk_val("edit_cont", 5'h19, edit);
    // Above setpoint the thermostat is idle, so only the test can hold the heater on.
    temp[0] = 12'd100;
    item = 2'h0;
    key(6);
    cyc(150);
    chk_bit("cont_on", 1'b1, heater[0]);
    for (i = 0; i < 25; i++) key(5);
    key(6);
    chk_bit("cont_cancel", 1'b0, heater[0]);
    key(4);
    item = 2'h2;
    key(6);
    for (i = 0; i < 30; i++)
    begin
      cyc(1);
      chk_bit("alarm_test", 1'b1, alarm & alamp & warn);
    end
    key(5);
    key(6);
    cyc(2);
    chk_bit("alarm_test_off", 1'b0, alarm | warn);
    for (i = 1; i < 4; i++)
    begin
      comm_evt = 1'b1;
      cyc(1);
      comm_evt = 1'b0;
      cyc(1);
      chk_bit("comm_lamp", i[0], clamp);
    end
    stats_clr = 1'b1;
    cyc(1);
    stats_clr = 1'b0;
    cyc(1);
    chk_bit("interval", 1'b1, (up_s - int_s) <= 32'd1);
    chk_val("on_sec0_clear", 0, on_s[0]);
    self_fail = 1'b1;
    cyc(1);
    chk_bit("fail_lamp", 1'b1, flamp);
    self_fail = 1'b0;
    cyc(1);
    chk_bit("fail_lamp_off", 1'b0, flamp);
    t = {row, col};
    cyc(1);
    chk_val("disp_scan", (t + 1) % 32, {row, col});
    // Two-second notices also make the default messages rotate every two seconds.
    flash_we = 1'b1;
    flash_s = 8'h02;
    cyc(1);
    flash_we = 1'b0;
    idle_s = 8'h02;
    key(2);
    chk_val("status_view", HTH_VIEW_STATUS, view);
    n = 0;
    while (view !== HTH_VIEW_DEFAULT && n < 100)
    begin
      cyc(1);
      n++;
    end
    // The key clears the idle count and the first second tick may come early.
    chk_bit("idle_return", 1'b1, n >= 21 && n <= 40);
    t = dmsg;
    n = 0;
    while (dmsg === t[1:0] && n < 50)
    begin
      cyc(1);
      n++;
    end
    chk_val("default_msg", (t == 2) ? 0 : t + 1, dmsg);
    key(2);
    chk_val("status_override", HTH_VIEW_STATUS, view);
    wrap_up();
  end
endmodule
